/* shared/isc_pkg.sv */
// Shared constants and types of the ISA-side signal controller.
// Assumes every user is clocked by the 25 MHz i_mclk.
package isc_pkg;

  // Cycle kinds announced by the cycle sequencer
  typedef enum logic [2:0] {
    ISC_CYC_NONE = 3'h0,
    ISC_CYC_EISA = 3'h1,
    ISC_CYC_DMA  = 3'h2,
    ISC_CYC_ISAM = 3'h3,
    ISC_CYC_REFR = 3'h4
  } isc_cyc_t;

  // Command kinds
  typedef enum logic [1:0] {
    ISC_CMD_MRD = 2'h0,
    ISC_CMD_MWR = 2'h1,
    ISC_CMD_IORD = 2'h2,
    ISC_CMD_IOWR = 2'h3
  } isc_cmd_t;

  // Bus ownership states
  typedef enum logic [2:0] {
    ISC_ST_IDLE = 3'h0,
    ISC_ST_EISA = 3'h1,
    ISC_ST_DMA  = 3'h2,
    ISC_ST_ISAM = 3'h3,
    ISC_ST_REFR = 3'h4
  } isc_state_t;

  // Values after reset, and the synchroniser depth
  localparam logic       RST_HIGH  = 1'h1;
  localparam logic       RST_LOW   = 1'h0;
  localparam logic [1:0] RST_SA    = 2'h0;
  localparam logic [3:0] RST_BE_N  = 4'hF;
  localparam int         SYNC_STAGES = 2;

endpackage : isc_pkg

/* core/isc_sync.sv */
// Two-flop synchroniser for pin inputs of any width.
// Assumes a single clock domain and active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module isc_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RST;
      q_reg    <= RST;
    end else if (i_ce) begin
      meta_reg <= i_d;
      q_reg    <= meta_reg;
    end
  end

  assign o_q = q_reg;
endmodule : isc_sync
`default_nettype wire

/* core/isc_be_conv.sv */
// Byte-enable to ISA low-address conversion, both directions.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`default_nettype none
module isc_be_conv (
  // ISA side in
  input  wire logic [1:0] i_sa,
  input  wire logic       i_sbhe_n,
  // EISA side in
  input  wire logic [3:0] i_be_n,
  // EISA byte enables from ISA address
  output logic      [3:0] o_be_n,
  // ISA address from byte enables
  output logic      [1:0] o_sa,
  output logic            o_sbhe_n
);
  wire       lo_en = ~i_sa[0];
  wire       hi_en = i_sa[0] | ~i_sbhe_n;
  wire [3:0] be    = ~i_be_n;
  wire [1:0] first = be[0] ? 2'h0 : be[1] ? 2'h1 :
                     be[2] ? 2'h2 : 2'h3;
  wire       upper = first[1] ? be[3] : (be[1] | be[3]);

  assign o_be_n = i_sa[1] ? {~hi_en, ~lo_en, 2'h3}
                          : {2'h3, ~hi_en, ~lo_en};
  assign o_sa     = first;
  assign o_sbhe_n = ~upper;
endmodule : isc_be_conv
`default_nettype wire

/* core/isc_ctrl.sv */
// ISA-side signal controller: direction, strobes, widths, ready.
// Assumes a cycle sequencer on i_mclk announcing each cycle.
`timescale 1ns/1ps
`default_nettype none
module isc_ctrl (
  // Clock, reset, enable
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  // Cycle sequencer
  input  wire logic       i_cyc_start,
  input  wire logic [2:0] i_cyc_type,
  input  wire logic       i_cyc_end,
  input  wire logic       i_cmd_act,
  input  wire logic [1:0] i_cmd_kind,
  input  wire logic       i_below_1m,
  input  wire logic       i_addr_valid,
  input  wire logic       i_compat_dma,
  input  wire logic [3:0] i_be_n,
  // Translation and targets
  input  wire logic       i_xlat,
  input  wire logic       i_ex32_n,
  input  wire logic       i_ex16_n,
  input  wire logic       i_int_tgt,
  input  wire logic       i_int_wait,
  input  wire logic       i_nmi_en,
  // ISA pins in
  input  wire logic       i_master16_n,
  input  wire logic [1:0] i_sa_in,
  input  wire logic       i_sbhe_in_n,
  input  wire logic       i_m16_in_n,
  input  wire logic       i_mrdc_in_n,
  input  wire logic       i_mwtc_in_n,
  input  wire logic       i_iorc_in_n,
  input  wire logic       i_iowc_in_n,
  input  wire logic       i_chrdy_in,
  input  wire logic       i_iochk_n,
  // ISA pins out
  output logic            o_bale,
  output logic [1:0]      o_sa_out,
  output logic            o_sa_oe,
  output logic            o_sbhe_out_n,
  output logic            o_sbhe_oe,
  output logic            o_m16_out_n,
  output logic            o_m16_oe,
  output logic            o_io16_oe,
  output logic            o_mrdc_out_n,
  output logic            o_mwtc_out_n,
  output logic            o_iorc_out_n,
  output logic            o_iowc_out_n,
  output logic            o_cmd_oe,
  output logic            o_smrdc_n,
  output logic            o_smwtc_n,
  output logic            o_chrdy_oe,
  // Toward the EISA side
  output logic [3:0]      o_be_n,
  output logic            o_isam_cmd,
  output logic            o_wait,
  output logic            o_isam,
  output logic            o_nmi
);
  localparam int N_SYNC = 10;

  isc_pkg::isc_state_t st_reg;
  isc_pkg::isc_state_t st_next;

  logic [N_SYNC-1:0] pins_s;
  logic [1:0]        sa_s;
  logic              sbhe_s_n;
  logic              m16_s_n;
  logic              mrdc_s_n;
  logic              mwtc_s_n;
  logic              iorc_s_n;
  logic              iowc_s_n;
  logic              chrdy_s;
  logic              iochk_s_n;
  logic              mst16_s_n;
  logic              iochk_prev_reg;
  logic [3:0]        conv_be_n;
  logic [1:0]        conv_sa;
  logic              conv_sbhe_n;

  logic              bale_reg;
  logic [1:0]        sa_reg;
  logic              sa_oe_reg;
  logic              sbhe_reg;
  logic              sbhe_oe_reg;
  logic              m16_oe_reg;
  logic              m16_drv_reg;
  logic              io16_oe_reg;
  logic [3:0]        cmd_n_reg;
  logic              cmd_oe_reg;
  logic              smrdc_reg;
  logic              smwtc_reg;
  logic              chrdy_oe_reg;
  logic [3:0]        be_n_reg;
  logic              isam_cmd_reg;
  logic              wait_reg;
  logic              nmi_reg;
  logic              isam_reg;

  // Pin synchronisers
  isc_sync #(
    .W   (N_SYNC),
    .RST ({N_SYNC{1'b1}})
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_d     ({i_master16_n, i_iochk_n, i_chrdy_in,
               i_iowc_in_n, i_iorc_in_n, i_mwtc_in_n,
               i_mrdc_in_n, i_m16_in_n, i_sbhe_in_n,
               i_sa_in[0]}),
    .o_q     (pins_s)
  );

  isc_sync #(
    .W   (1),
    .RST (1'b0)
  ) u_sync_sa1 (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_d     (i_sa_in[1]),
    .o_q     (sa_s[1])
  );

  assign sa_s[0]   = pins_s[0];
  assign sbhe_s_n  = pins_s[1];
  assign m16_s_n   = pins_s[2];
  assign mrdc_s_n  = pins_s[3];
  assign mwtc_s_n  = pins_s[4];
  assign iorc_s_n  = pins_s[5];
  assign iowc_s_n  = pins_s[6];
  assign chrdy_s   = pins_s[7];
  assign iochk_s_n = pins_s[8];
  assign mst16_s_n = pins_s[9];

  isc_be_conv u_conv (
    .i_sa     (sa_s),
    .i_sbhe_n (sbhe_s_n),
    .i_be_n   (i_be_n),
    .o_be_n   (conv_be_n),
    .o_sa     (conv_sa),
    .o_sbhe_n (conv_sbhe_n)
  );

  wire ext_master = ~mst16_s_n;
  wire is_isam_t  = i_cyc_type == 3'(isc_pkg::ISC_CYC_ISAM);
  wire start_isam = i_cyc_start & (ext_master | is_isam_t)
                    & (i_cyc_type != 3'(isc_pkg::ISC_CYC_REFR));

  always_comb begin
    st_next = st_reg;
    if (i_cyc_end) begin
      st_next = isc_pkg::ISC_ST_IDLE;
    end else if (start_isam) begin
      st_next = isc_pkg::ISC_ST_ISAM;
    end else if (i_cyc_start) begin
      unique case (i_cyc_type)
        3'(isc_pkg::ISC_CYC_EISA): st_next = isc_pkg::ISC_ST_EISA;
        3'(isc_pkg::ISC_CYC_DMA):  st_next = isc_pkg::ISC_ST_DMA;
        3'(isc_pkg::ISC_CYC_REFR): st_next = isc_pkg::ISC_ST_REFR;
        default:                   st_next = isc_pkg::ISC_ST_IDLE;
      endcase
    end
  end

  wire in_eisa = st_next == isc_pkg::ISC_ST_EISA;
  wire in_dma  = st_next == isc_pkg::ISC_ST_DMA;
  wire in_isam = st_next == isc_pkg::ISC_ST_ISAM;
  wire in_refr = st_next == isc_pkg::ISC_ST_REFR;
  wire own     = in_eisa | in_dma | in_refr;
  wire drv_adr = in_eisa | in_dma;

  wire bale_nx = (drv_adr & i_addr_valid) | in_dma
                 | in_isam | in_refr;

  // Command strobes from the selected kind
  wire       cmd_on = own & i_cmd_act;
  wire [1:0] kind   = in_refr ? 2'(isc_pkg::ISC_CMD_MRD)
                              : i_cmd_kind;
  wire [3:0] cmd_nx = cmd_on ? ~(4'h1 << kind) : 4'hF;

  wire smrd_nx = cmd_on & (in_refr |
                 (kind == 2'(isc_pkg::ISC_CMD_MRD) & i_below_1m));
  wire smwt_nx = cmd_on & ~in_refr & i_below_1m &
                 (kind == 2'(isc_pkg::ISC_CMD_MWR));

  wire wait_nx = (own | (in_dma & i_compat_dma)) & ~chrdy_s;
  // Ready held low for internal targets while i_int_wait is set
  wire rdy_nx  = in_isam & i_int_tgt & i_int_wait;
  // Width select driven to external master while translating and i_ex32_n or i_ex16_n is low
  wire m16o_nx = in_isam & i_xlat;

  wire [3:0] be_nx = in_isam ? conv_be_n : isc_pkg::RST_BE_N;
  wire isam_cmd_nx = in_isam & ~(mrdc_s_n & mwtc_s_n &
                                 iorc_s_n & iowc_s_n);

  wire nmi_nx = i_nmi_en & ~iochk_s_n & iochk_prev_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg         <= isc_pkg::ISC_ST_IDLE;
      bale_reg       <= isc_pkg::RST_LOW;
      sa_reg         <= isc_pkg::RST_SA;
      sa_oe_reg      <= isc_pkg::RST_LOW;
      sbhe_reg       <= isc_pkg::RST_HIGH;
      sbhe_oe_reg    <= isc_pkg::RST_LOW;
      m16_oe_reg     <= isc_pkg::RST_LOW;
      io16_oe_reg    <= isc_pkg::RST_LOW;
      cmd_n_reg      <= 4'hF;
      cmd_oe_reg     <= isc_pkg::RST_LOW;
      smrdc_reg      <= isc_pkg::RST_HIGH;
      smwtc_reg      <= isc_pkg::RST_HIGH;
      chrdy_oe_reg   <= isc_pkg::RST_LOW;
      be_n_reg       <= isc_pkg::RST_BE_N;
      isam_cmd_reg   <= isc_pkg::RST_LOW;
      wait_reg       <= isc_pkg::RST_LOW;
      nmi_reg        <= isc_pkg::RST_LOW;
      isam_reg       <= isc_pkg::RST_LOW;
      iochk_prev_reg <= isc_pkg::RST_HIGH;
    end else if (i_ce) begin
      st_reg         <= st_next;
      bale_reg       <= bale_nx;
      // Low address and high enable driven
      sa_reg         <= drv_adr ? conv_sa : isc_pkg::RST_SA;
      sa_oe_reg      <= drv_adr;
      sbhe_reg       <= drv_adr ? conv_sbhe_n : isc_pkg::RST_HIGH;
      sbhe_oe_reg    <= drv_adr;
      m16_oe_reg     <= m16o_nx;
      io16_oe_reg    <= isc_pkg::RST_LOW;
      cmd_n_reg      <= cmd_nx;
      cmd_oe_reg     <= own;
      smrdc_reg      <= ~smrd_nx;
      smwtc_reg      <= ~smwt_nx;
      chrdy_oe_reg   <= rdy_nx;
      be_n_reg       <= be_nx;
      isam_cmd_reg   <= isam_cmd_nx;
      wait_reg       <= wait_nx;
      nmi_reg        <= nmi_nx;
      isam_reg       <= in_isam;
      iochk_prev_reg <= iochk_s_n;
    end
  end

  assign o_m16_out_n  = ~m16_oe_reg | (i_ex32_n & i_ex16_n);
  assign o_bale       = bale_reg;
  assign o_sa_out     = sa_reg;
  assign o_sa_oe      = sa_oe_reg;
  assign o_sbhe_out_n = sbhe_reg;
  assign o_sbhe_oe    = sbhe_oe_reg;
  assign o_m16_oe     = m16_oe_reg & ~(i_ex32_n & i_ex16_n);
  assign o_io16_oe    = io16_oe_reg;
  assign o_mrdc_out_n = cmd_n_reg[0];
  assign o_mwtc_out_n = cmd_n_reg[1];
  assign o_iorc_out_n = cmd_n_reg[2];
  assign o_iowc_out_n = cmd_n_reg[3];
  assign o_cmd_oe     = cmd_oe_reg;
  assign o_smrdc_n    = smrdc_reg;
  assign o_smwtc_n    = smwtc_reg;
  assign o_chrdy_oe   = chrdy_oe_reg;
  assign o_be_n       = be_n_reg;
  assign o_isam_cmd   = isam_cmd_reg;
  assign o_wait       = wait_reg;
  assign o_isam       = isam_reg;
  assign o_nmi        = nmi_reg;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  wire st_dma  = st_reg == isc_pkg::ISC_ST_DMA;
  wire st_refr = st_reg == isc_pkg::ISC_ST_REFR;
  wire st_isam = st_reg == isc_pkg::ISC_ST_ISAM;

  bale_hold_a: assert property (
    (st_dma | st_refr | st_isam) |-> o_bale)
    else $error("bale low in held cycle");
  sa_dir_a: assert property (
    st_isam |-> !o_sa_oe && !o_sbhe_oe)
    else $error("sa driven by device in isa master cycle");
  be_from_sa_a: assert property (
    i_ce && in_isam && sa_s == 2'h1 && sbhe_s_n
      |=> o_be_n == 4'hD)
    else $error("byte enable wrong for odd byte");
  sa_from_be_a: assert property (
    i_ce && st_next == isc_pkg::ISC_ST_EISA && i_be_n == 4'h3
      |=> o_sa_out == 2'h2 && !o_sbhe_out_n && o_sa_oe)
    else $error("driven address wrong for upper word");
  cmd_release_a: assert property (
    !(st_reg inside {isc_pkg::ISC_ST_EISA, isc_pkg::ISC_ST_DMA,
      isc_pkg::ISC_ST_REFR}) |-> !o_cmd_oe && !o_sa_oe)
    else $error("driver active while bus not owned");
  refr_read_a: assert property (
    i_ce && in_refr && i_cmd_act
      |=> !o_mrdc_out_n && !o_smrdc_n && o_mwtc_out_n)
    else $error("refresh read strobe missing");
  sys_mem_a: assert property (
    !o_smwtc_n |-> !o_mwtc_out_n && $past(i_below_1m))
    else $error("system write above 1 MByte");
  io16_never_a: assert property (
    !o_io16_oe)
    else $error("io16 driven");
  chrdy_ign_a: assert property (
    i_ce && in_isam && !i_int_tgt |=> !o_chrdy_oe && !o_wait)
    else $error("ready used for isa to isa cycle");
  m16_comb_a: assert property (
    m16_oe_reg && !i_ex16_n |-> o_m16_oe && !o_m16_out_n)
    else $error("width select not asserted");
  nmi_edge_a: assert property (
    i_ce && i_nmi_en && iochk_prev_reg && !iochk_s_n
      |=> o_nmi ##1 (!o_nmi || !i_ce))
    else $error("nmi not a single pulse");
  wait_ext_a: assert property (
    i_ce && own && !chrdy_s |=> o_wait)
    else $error("wait not requested");

  cov_isam_c: cover property (st_isam ##1 o_isam_cmd);
  cov_refr_c: cover property (st_refr && !o_mrdc_out_n);
  cov_nmi_c:  cover property (o_nmi);
  cov_wait_c: cover property (o_wait [*3]);
endmodule : isc_ctrl
`default_nettype wire

/* bench/isc_slave_model.sv */
// ISA slave model standing on the far side of the controller.
// Assumes the bench joins its pulls to open-drain wires with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module isc_slave_model (
  // Clock and bench controls
  input  wire logic        i_mclk,
  input  wire logic        i_is16,
  input  wire logic        i_slow,
  input  wire logic        i_err,
  // Commands seen on the bus
  input  wire logic        i_bale,
  input  wire logic        i_mrdc_n,
  input  wire logic        i_iorc_n,
  // Pulls and data
  output logic             o_m16_pull,
  output logic             o_io16_pull,
  output logic             o_chrdy_pull,
  output logic             o_iochk_n,
  output logic [15:0]      o_sd
);
  logic iorc_d_reg = 1'h0;
  logic tgl_reg    = 1'h0;
  logic bale_d_reg = 1'h0;
  logic sel16_reg  = 1'h0;
  // decode latched on trailing edge of BALE
  always @(posedge i_mclk) begin
    bale_d_reg <= i_bale;
    if (bale_d_reg & ~i_bale) begin
      sel16_reg <= i_is16;
    end
  end
  assign o_m16_pull   = sel16_reg & ~i_mrdc_n;
  assign o_io16_pull  = i_is16 & ~i_iorc_n;
  assign o_chrdy_pull = i_slow;
  assign o_iochk_n    = ~i_err;
  // read data held past read negation
  always @(posedge i_mclk) begin
    iorc_d_reg <= ~i_iorc_n;
    tgl_reg    <= ~tgl_reg;
  end
  assign o_sd = (~i_iorc_n | iorc_d_reg) ? 16'h5AA5 : {16{tgl_reg}};
endmodule : isc_slave_model
`default_nettype wire

/* bench/tb_isc_ctrl.sv */
// Self-checking bench for the ISA-side signal controller.
// Assumes the slave model on the far side and pull-ups on open drains.
`timescale 1ns/1ps
`default_nettype none
module tb_isc_ctrl;
  logic       i_mclk, i_rst_n, i_ce, i_cyc_start, i_cyc_end, i_cmd_act;
  logic       i_below_1m, i_addr_valid, i_compat_dma, i_xlat, i_ex32_n;
  logic       i_ex16_n, i_int_tgt, i_int_wait, i_nmi_en, i_master16_n;
  logic       i_sbhe_in_n, i_mrdc_in_n, i_mwtc_in_n, i_iorc_in_n;
  logic       i_iowc_in_n, p_slow, p_err, p_is16;
  logic [2:0] i_cyc_type;
  logic [1:0] i_cmd_kind, i_sa_in, o_sa_out;
  logic [3:0] i_be_n, o_be_n;
  logic       o_bale, o_sa_oe, o_sbhe_out_n, o_sbhe_oe, o_m16_out_n;
  logic       o_m16_oe, o_io16_oe, o_mrdc_out_n, o_mwtc_out_n, o_iorc_out_n;
  logic       o_iowc_out_n, o_cmd_oe, o_smrdc_n, o_smwtc_n, o_chrdy_oe;
  logic       o_isam_cmd, o_wait, o_isam, o_nmi;
  wire        i_m16_in_n, i_chrdy_in, i_iochk_n, m16_pull, chrdy_pull;
  wire [15:0] sd;
  int         errors, compares, n;

  // Open-drain pins with pull-ups
  assign i_m16_in_n = ~((o_m16_oe & ~o_m16_out_n) | m16_pull);
  assign i_chrdy_in = ~(o_chrdy_oe | chrdy_pull);

  isc_ctrl u_dut (
    .i_mclk, .i_rst_n, .i_ce, .i_cyc_start, .i_cyc_type, .i_cyc_end,
    .i_cmd_act, .i_cmd_kind, .i_below_1m, .i_addr_valid, .i_compat_dma,
    .i_be_n, .i_xlat, .i_ex32_n, .i_ex16_n, .i_int_tgt, .i_int_wait,
    .i_nmi_en, .i_master16_n, .i_sa_in, .i_sbhe_in_n, .i_m16_in_n,
    .i_mrdc_in_n, .i_mwtc_in_n, .i_iorc_in_n, .i_iowc_in_n, .i_chrdy_in,
    .i_iochk_n, .o_bale, .o_sa_out, .o_sa_oe, .o_sbhe_out_n, .o_sbhe_oe,
    .o_m16_out_n, .o_m16_oe, .o_io16_oe, .o_mrdc_out_n, .o_mwtc_out_n,
    .o_iorc_out_n, .o_iowc_out_n, .o_cmd_oe, .o_smrdc_n, .o_smwtc_n,
    .o_chrdy_oe, .o_be_n, .o_isam_cmd, .o_wait, .o_isam, .o_nmi
  );

  isc_slave_model u_slave (
    .i_mclk(i_mclk), .i_is16(p_is16), .i_slow(p_slow), .i_err(p_err),
    .i_bale(o_bale),
    .i_mrdc_n(o_cmd_oe ? o_mrdc_out_n : i_mrdc_in_n),
    .i_iorc_n(o_cmd_oe ? o_iorc_out_n : i_iorc_in_n),
    .o_m16_pull(m16_pull), .o_io16_pull(), .o_chrdy_pull(chrdy_pull),
    .o_iochk_n(i_iochk_n), .o_sd(sd)
  );

  always #20 i_mclk = ~i_mclk;

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_edges(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask : wait_edges

  task automatic begin_cyc(input logic [2:0] t);
    @(posedge i_mclk);
    i_cyc_type  <= t;
    i_cyc_start <= 1'h1;
    @(posedge i_mclk);
    i_cyc_start <= 1'h0;
  endtask : begin_cyc

  task automatic end_cyc;
    @(posedge i_mclk);
    i_cmd_act <= 1'h0;
    i_cyc_end <= 1'h1;
    @(posedge i_mclk);
    i_cyc_end <= 1'h0;
    #1;
    chk({o_bale, o_sa_oe, o_sbhe_oe, o_cmd_oe}, 4'h0);
  endtask : end_cyc

  task automatic report_and_stop;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic t_dma;
    i_be_n       <= 4'hC;
    i_compat_dma <= 1'h1;
    begin_cyc(3'h2);
    i_cmd_act  <= 1'h1;
    i_cmd_kind <= 2'h0;
    i_below_1m <= 1'h1;
    #1;
    chk({o_bale, o_sa_oe, o_sbhe_oe, o_cmd_oe}, 4'hF);
    chk({o_sa_out, o_sbhe_out_n}, 3'h0);
    wait_edges(1);
    chk({o_mrdc_out_n, o_smrdc_n}, 2'h0);
    @(posedge i_mclk);
    p_slow <= 1'h1;
    wait_edges(4);
    chk(o_wait, 1'h1);
    @(posedge i_mclk);
    p_slow <= 1'h0;
    wait_edges(4);
    chk(o_wait, 1'h0);
    @(posedge i_mclk);
    i_ce   <= 1'h0;
    p_slow <= 1'h1;
    wait_edges(4);
    chk(o_wait, 1'h0);
    @(posedge i_mclk);
    i_ce   <= 1'h1;
    p_slow <= 1'h0;
    wait_edges(4);
    end_cyc();
  endtask : t_dma

  task automatic t_eisa;
    for (int i = 0; i < 8; i++) begin
      i_be_n       <= i[0] ? 4'h3 : 4'h7;
      i_addr_valid <= 1'h1;
      begin_cyc(3'h1);
      i_cmd_act  <= 1'h1;
      i_cmd_kind <= i[1:0];
      i_below_1m <= i[2];
      wait_edges(1);
      chk(o_bale, 1'h1);
      chk({o_sa_out, o_sbhe_out_n}, i[0] ? 3'h4 : 3'h6);
      chk({o_iowc_out_n, o_iorc_out_n, o_mwtc_out_n, o_mrdc_out_n},
          ~(4'h1 << i[1:0]));
      chk({o_smwtc_n, o_smrdc_n}, {i != 5, i != 4});
      end_cyc();
    end
  endtask : t_eisa

  task automatic t_refresh;
    begin_cyc(3'h4);
    i_cmd_act  <= 1'h1;
    i_cmd_kind <= 2'h0;
    i_below_1m <= 1'h0;
    wait_edges(1);
    chk(o_bale, 1'h1);
    chk(o_mrdc_out_n, 1'h0);
    chk(o_smrdc_n, 1'h0);
    end_cyc();
  endtask : t_refresh

  task automatic t_isam;
    @(posedge i_mclk);
    i_master16_n <= 1'h0;
    i_sa_in      <= 2'h2;
    i_sbhe_in_n  <= 1'h0;
    wait_edges(3);
    begin_cyc(3'h3);
    wait_edges(3);
    chk(o_isam, 1'h1);
    chk({o_sa_oe, o_sbhe_oe, o_cmd_oe, o_io16_oe}, 4'h0);
    chk(o_be_n, 4'h3);
    i_sa_in     <= 2'h1;
    i_sbhe_in_n <= 1'h1;
    wait_edges(3);
    chk(o_be_n, 4'hD);
    i_iorc_in_n <= 1'h0;
    p_slow      <= 1'h1;
    wait_edges(4);
    chk(o_isam_cmd, 1'h1);
    chk(o_wait, 1'h0);
    chk(o_io16_oe, 1'h0);
    p_slow     <= 1'h0;
    i_int_tgt  <= 1'h1;
    i_int_wait <= 1'h1;
    i_xlat     <= 1'h1;
    i_ex16_n   <= 1'h0;
    wait_edges(2);
    chk(o_chrdy_oe, 1'h1);
    chk({o_m16_oe, o_m16_out_n}, 2'h2);
    i_ex16_n <= 1'h1;
    #1;
    chk({o_m16_oe, o_m16_out_n}, 2'h1);
    i_ex32_n <= 1'h0;
    #1;
    chk({o_m16_oe, o_m16_out_n}, 2'h2);
    i_ex32_n     <= 1'h1;
    i_xlat       <= 1'h0;
    i_int_tgt    <= 1'h0;
    i_iorc_in_n  <= 1'h1;
    i_master16_n <= 1'h1;
    end_cyc();
    wait_edges(3);
  endtask : t_isam

  task automatic t_nmi(input logic en);
    @(posedge i_mclk);
    i_nmi_en <= en;
    p_err    <= 1'h1;
    n = 0;
    repeat (6) begin
      wait_edges(1);
      n += (o_nmi === 1'h1);
    end
    chk(n[3:0], {3'h0, en});
    p_err <= 1'h0;
    wait_edges(4);
  endtask : t_nmi

  initial begin
    {i_mclk, i_rst_n, i_cyc_start, i_cyc_end, i_cmd_act} = '0;
    {i_below_1m, i_addr_valid, i_compat_dma, i_xlat, i_nmi_en} = '0;
    {i_int_tgt, i_int_wait, p_slow, p_err, p_is16} = '0;
    {i_ce, i_ex32_n, i_ex16_n, i_master16_n, i_sbhe_in_n} = '1;
    {i_mrdc_in_n, i_mwtc_in_n, i_iorc_in_n, i_iowc_in_n} = '1;
    {i_cyc_type, i_cmd_kind, i_sa_in, i_be_n} = '0;
    errors   = 0;
    compares = 0;
    repeat (5) @(posedge i_mclk);
    #1;
    chk({o_bale, o_cmd_oe, o_sa_oe, o_nmi}, 4'h0);
    chk(o_be_n, 4'hF);
    @(posedge i_mclk);
    i_rst_n <= 1'h1;
    wait_edges(3);
    t_dma();
    t_eisa();
    t_refresh();
    p_is16 <= 1'h1;
    t_isam();
    t_nmi(1'h1);
    t_nmi(1'h0);
    report_and_stop();
  end

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule : tb_isc_ctrl
`default_nettype wire
